// ### rtl/drv_status_cfg.svh
// offsets, field positions, reset values and timing counts of the
// driver status/control bank; assumes a 32-bit byte-addressed port, one word every 4 offsets.
`ifndef DRV_STATUS_CFG_SVH
`define DRV_STATUS_CFG_SVH

`define ADDR_W 8
`define OFF_STATUS 8'h00
`define OFF_IRQ_STAT 8'h04
`define OFF_IRQ_EN 8'h08
`define OFF_IRQ_CLR 8'h0c

`define ON_MSB 31
`define ON_LSB 24
`define MASK_MSB 23
`define MASK_LSB 17
`define OSC_BIT 16
`define MODE_MSB 15
`define MODE_LSB 8
`define FLAG_MSB 7
`define FLAG_LSB 1
`define ACTIVE_BIT 0

// mask order matches flag order: thermal .. undervoltage
`define MASK_RST 7'h02
`define UV_RST 1'h1

`define CLK_HZ 20000000
`define OSC_HI_HZ 100000
`define OSC_LO_HZ 80000
`define OSC_HI_CYC (`CLK_HZ / `OSC_HI_HZ)
`define OSC_LO_CYC (`CLK_HZ / `OSC_LO_HZ)

`endif

// ### rtl/drv_status_pkg.sv
// types of the driver status/control bank; no assumptions.
package drv_status_pkg;

  typedef enum logic [1:0] {
    PM_INDEP,
    PM_PARALLEL,
    PM_HBRIDGE,
    PM_RESERVED
  } pair_mode_t;

  typedef struct packed {
    logic [7:0] on;
    logic [6:0] mask;
    logic osc_sel;
    logic [3:0][1:0] mode;
    logic therm;
    logic uv;
    logic active;
    logic [6:0] ist;
    logic [6:0] ien;
    logic [6:0] prev;
    logic [31:0] rdata;
    logic fault_n;
    logic irq;
    logic [7:0] en;
    logic [7:0] hs;
    logic [7:0] ls;
    logic [7:0] sel;
    logic [7:0] osc_cnt;
    logic tick;
  } state_t;

endpackage

// ### rtl/driver_status_control_register.sv
// status/control register bank of an octal half-bridge driver.
// assumes a synchronous master on a plain strobe port, fault sources
// synchronous to sys_clk_i.
`timescale 1ns/1ns
`include "drv_status_cfg.svh"

module driver_status_control_register (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic thermal_i,
  input wire logic overcurrent_i,
  input wire logic open_load_i,
  input wire logic hit_miss_i,
  input wire logic plunger_i,
  input wire logic comm_error_i,
  input wire logic undervoltage_i,
  output logic [7:0] ch_en_o,
  output logic [7:0] ch_hs_o,
  output logic [7:0] ch_ls_o,
  output logic [7:0] ch_cfg_partner_o,
  output logic active_o,
  output logic osc_sel_o,
  output logic pwm_tick_o,
  output logic fault_n_o,
  output logic irq_o
);

  drv_status_pkg::state_t st_reg;
  drv_status_pkg::state_t st_next;
  logic [6:0] flags;
  logic [6:0] wr_clr;
  logic [7:0] osc_lim;
  logic rd_status;
  logic wr_status;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // one pair: returns {en[1:0], hs[1:0], ls[1:0], sel[1:0]}, [1] is upper
  function automatic logic [7:0] pair_decode(input logic [1:0] mode,
                                             input logic [1:0] on,
                                             input logic par_hi);
    logic [1:0] en;
    logic [1:0] hs;
    logic [1:0] ls;
    logic [1:0] sel;
    en = on;
    hs = 2'h0;
    ls = 2'h0;
    sel = 2'h0;
    unique case (drv_status_pkg::pair_mode_t'(mode))
      drv_status_pkg::PM_INDEP: begin
        en = on;
      end
      drv_status_pkg::PM_PARALLEL: begin
        en = {2{par_hi ? on[1] : on[0]}};
        sel = 2'h2;
      end
      drv_status_pkg::PM_HBRIDGE: begin
        // low-side pwm follows the lower channel's configuration
        sel = 2'h2;
        unique case (on)
          2'h0: begin
            en = 2'h0;
          end
          2'h1: begin
            en = 2'h3;
            hs = 2'h1;
            ls = 2'h2;
          end
          2'h2: begin
            en = 2'h3;
            hs = 2'h2;
            ls = 2'h1;
          end
          2'h3: begin
            en = 2'h3;
            ls = 2'h3;
          end
        endcase
      end
      drv_status_pkg::PM_RESERVED: begin
        // reserved code drives nothing rather than guess
        en = 2'h0;
      end
    endcase
    return {en, hs, ls, sel};
  endfunction

  assign rd_status = rd_i && hit(addr_i, `OFF_STATUS);
  assign wr_status = wr_i && hit(addr_i, `OFF_STATUS);
  assign wr_clr = (wr_i && hit(addr_i, `OFF_IRQ_CLR)) ? wdata_i[6:0] : 7'h00;
  assign flags = {st_reg.therm, overcurrent_i, open_load_i, hit_miss_i,
                  plunger_i, comm_error_i, st_reg.uv};
  assign osc_lim = st_reg.osc_sel ? 8'(`OSC_LO_CYC - 1)
                                  : 8'(`OSC_HI_CYC - 1);

  always_comb begin
    logic [7:0] dec;
    dec = 8'h00;
    st_next = st_reg;
    st_next.rdata = 32'h0;
    if (wr_status) begin
      st_next.on = wdata_i[`ON_MSB:`ON_LSB];
      st_next.mask = wdata_i[`MASK_MSB:`MASK_LSB];
      st_next.osc_sel = wdata_i[`OSC_BIT];
      st_next.active = wdata_i[`ACTIVE_BIT];
      // a mode change under a live pair is dropped silently
      for (int p = 0; p < 4; p++) begin
        if (st_reg.on[2*p +: 2] == 2'h0) begin
          st_next.mode[p] = wdata_i[`MODE_LSB + 2*p +: 2];
        end
      end
    end
    if (wr_i && hit(addr_i, `OFF_IRQ_EN)) begin
      st_next.ien = wdata_i[6:0];
    end
    // a raised source beats a clearing read
    st_next.therm = thermal_i | (st_reg.therm & ~rd_status);
    st_next.uv = undervoltage_i | (st_reg.uv & ~rd_status);
    st_next.prev = flags;
    st_next.ist = (flags & ~st_reg.prev) | (st_reg.ist & ~wr_clr);
    st_next.irq = |(st_reg.ist & st_reg.ien);
    st_next.fault_n = ~|(flags & ~st_reg.mask);
    if (rd_i) begin
      if (hit(addr_i, `OFF_STATUS)) begin
        st_next.rdata = {st_reg.on, st_reg.mask, st_reg.osc_sel,
                         st_reg.mode, flags, st_reg.active};
      end else if (hit(addr_i, `OFF_IRQ_STAT)) begin
        st_next.rdata = {25'h0, st_reg.ist};
      end else if (hit(addr_i, `OFF_IRQ_EN)) begin
        st_next.rdata = {25'h0, st_reg.ien};
      end
    end
    for (int p = 0; p < 4; p++) begin
      dec = pair_decode(st_reg.mode[p], st_reg.on[2*p +: 2], p == 2);
      st_next.en[2*p +: 2] = st_reg.active ? dec[7:6] : 2'h0;
      st_next.hs[2*p +: 2] = st_reg.active ? dec[5:4] : 2'h0;
      st_next.ls[2*p +: 2] = st_reg.active ? dec[3:2] : 2'h0;
      st_next.sel[2*p +: 2] = dec[1:0];
    end
    // >= so a switch to the faster rate never overruns the limit
    if (st_reg.osc_cnt >= osc_lim) begin
      st_next.osc_cnt = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.osc_cnt = st_reg.osc_cnt + 8'h01;
      st_next.tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.mask <= `MASK_RST;
      st_reg.uv <= `UV_RST;
      st_reg.prev <= 7'h01;
      st_reg.fault_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign ch_en_o = st_reg.en;
  assign ch_hs_o = st_reg.hs;
  assign ch_ls_o = st_reg.ls;
  assign ch_cfg_partner_o = st_reg.sel;
  assign active_o = st_reg.active;
  assign osc_sel_o = st_reg.osc_sel;
  assign pwm_tick_o = st_reg.tick;
  assign fault_n_o = st_reg.fault_n;
  assign irq_o = st_reg.irq;

  // helper: cycles since the last tick and whether the rate moved
  logic [8:0] gap_reg;
  logic osc_chg_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_reg <= 9'h000;
      osc_chg_reg <= 1'b1;
    end else if (pwm_tick_o) begin
      gap_reg <= 9'h001;
      osc_chg_reg <= 1'b0;
    end else begin
      gap_reg <= gap_reg + 9'h001;
      osc_chg_reg <= osc_chg_reg | (st_next.osc_sel != st_reg.osc_sel);
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_on_bits;
    (st_reg.active && st_reg.mode[0] == 2'h0)
      |=> ch_en_o[1:0] == $past(st_reg.on[1:0]);
  endproperty
  a_on_bits: assert property (p_on_bits)
    else $error("independent channel enable does not follow on bit");

  property p_thermal_pin;
    (st_reg.therm && !st_reg.mask[6]) |=> !fault_n_o;
  endproperty
  a_thermal_pin: assert property (p_thermal_pin)
    else $error("unmasked thermal flag left fault pin high");

  property p_all_masked;
    (&st_reg.mask) |=> fault_n_o;
  endproperty
  a_all_masked: assert property (p_all_masked)
    else $error("fault pin low with every fault masked");

  property p_uv_pin;
    (st_reg.uv && !st_reg.mask[0]) |=> !fault_n_o;
  endproperty
  a_uv_pin: assert property (p_uv_pin)
    else $error("unmasked undervoltage left fault pin high");

  property p_osc_period;
    (pwm_tick_o && !osc_chg_reg)
      |-> gap_reg == (osc_sel_o ? 9'(`OSC_LO_CYC) : 9'(`OSC_HI_CYC));
  endproperty
  a_osc_period: assert property (p_osc_period)
    else $error("oscillator tick period wrong for selected rate");

  property p_mode_locked;
    (wr_status && st_reg.on[7:6] != 2'h0) |=> $stable(st_reg.mode[3]);
  endproperty
  a_mode_locked: assert property (p_mode_locked)
    else $error("ch7/6 mode changed while a channel was on");

  property p_parallel76;
    (st_reg.active && st_reg.mode[3] == 2'h1)
      |=> ch_en_o[7:6] == {2{$past(st_reg.on[6])}} && ch_cfg_partner_o[7];
  endproperty
  a_parallel76: assert property (p_parallel76)
    else $error("ch7/6 parallel mode not driven by ch6");

  property p_brake76;
    (st_reg.active && st_reg.mode[3] == 2'h2 && st_reg.on[7:6] == 2'h3)
      |=> ch_en_o[7:6] == 2'h3 && ch_ls_o[7:6] == 2'h3 && ch_hs_o[7:6] == 2'h0;
  endproperty
  a_brake76: assert property (p_brake76)
    else $error("ch7/6 brake not both low sides");

  property p_fwd54;
    (st_reg.active && st_reg.mode[2] == 2'h2 && st_reg.on[5:4] == 2'h1)
      |=> ch_hs_o[5:4] == 2'h1 && ch_ls_o[5:4] == 2'h2;
  endproperty
  a_fwd54: assert property (p_fwd54)
    else $error("ch5/4 forward drive wrong");

  property p_thermal_flag;
    thermal_i |=> st_reg.therm ##1 (st_reg.therm || $past(rd_status));
  endproperty
  a_thermal_flag: assert property (p_thermal_flag)
    else $error("thermal flag not set by thermal event");

  property p_inactive_off;
    !st_reg.active |=> ch_en_o == 8'h00;
  endproperty
  a_inactive_off: assert property (p_inactive_off)
    else $error("channel enabled while chip inactive");

  property p_read_clear;
    (rd_status && !thermal_i && !undervoltage_i)
      |=> !st_reg.therm && !st_reg.uv;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear thermal and uv flags");

  property p_ocp_pin;
    (overcurrent_i && !st_reg.mask[5])
      |=> !fault_n_o;
  endproperty
  a_ocp_pin: assert property (p_ocp_pin)
    else $error("unmasked overcurrent left fault pin high");

  property p_osc_write;
    wr_status
      |=> osc_sel_o == $past(wdata_i[`OSC_BIT]);
  endproperty
  a_osc_write: assert property (p_osc_write)
    else $error("oscillator select not taken from status write");

  property p_hiz76;
    (st_reg.active && st_reg.mode[3] == 2'h2 && st_reg.on[7:6] == 2'h0)
      |=> ch_en_o[7:6] == 2'h0;
  endproperty
  a_hiz76: assert property (p_hiz76)
    else $error("ch7/6 high impedance state still drives");

  property p_mode_locked54;
    (wr_status && st_reg.on[5:4] != 2'h0)
      |=> $stable(st_reg.mode[2]);
  endproperty
  a_mode_locked54: assert property (p_mode_locked54)
    else $error("ch5/4 mode changed while a channel was on");

  property p_parallel54;
    (st_reg.active && st_reg.mode[2] == 2'h1)
      |=> ch_en_o[5:4] == {2{$past(st_reg.on[5])}} && ch_cfg_partner_o[5];
  endproperty
  a_parallel54: assert property (p_parallel54)
    else $error("ch5/4 parallel mode not driven by ch5 on bit");

  property p_rev54;
    (st_reg.active && st_reg.mode[2] == 2'h2 && st_reg.on[5:4] == 2'h2)
      |=> ch_hs_o[5:4] == 2'h2 && ch_ls_o[5:4] == 2'h1;
  endproperty
  a_rev54: assert property (p_rev54)
    else $error("ch5/4 reverse drive wrong");

  property p_comm_flag;
    (rd_status && comm_error_i)
      |=> rdata_o[2];
  endproperty
  a_comm_flag: assert property (p_comm_flag)
    else $error("comm error flag not shown in status read");

  property p_uv_sticky;
    (st_reg.uv && !rd_status)
      |=> st_reg.uv;
  endproperty
  a_uv_sticky: assert property (p_uv_sticky)
    else $error("undervoltage flag dropped without a status read");

endmodule

// ### verif/host_model.sv
// host side of the status bank: issues one-word register accesses.
// assumes a free-running sys_clk_i; the bench calls these tasks.
`timescale 1ns/1ns

module host_model (
  input wire logic sys_clk_i,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [31:0] rdata_i
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // slave never stalls, so one strobe cycle completes the write
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask

  // read data only stand in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

// ### verif/tb_driver_status_control_register.sv
// bench of the status/control bank: register tests through the host.
// assumes the host model and the bank's include file are compiled.
`timescale 1ns/1ns
`include "drv_status_cfg.svh"

module tb_driver_status_control_register;
  logic sys_clk_i;
  logic rst_i;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [6:0] flt;
  logic [7:0] en, hs, ls, par;
  logic act, osc, tick, fault_n, irq;
  logic [31:0] rv;
  logic [3:0] hs_tab [4] = '{4'h0, 4'h5, 4'ha, 4'h0};
  logic [3:0] ls_tab [4] = '{4'h0, 4'ha, 4'h5, 4'hf};
  int miscompares = 0;
  int check_count = 0;
  int n;

  driver_status_control_register u_driver_status_control_register (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .thermal_i(flt[6]),
    .overcurrent_i(flt[5]),
    .open_load_i(flt[4]),
    .hit_miss_i(flt[3]),
    .plunger_i(flt[2]),
    .comm_error_i(flt[1]),
    .undervoltage_i(flt[0]),
    .ch_en_o(en),
    .ch_hs_o(hs),
    .ch_ls_o(ls),
    .ch_cfg_partner_o(par),
    .active_o(act),
    .osc_sel_o(osc),
    .pwm_tick_o(tick),
    .fault_n_o(fault_n),
    .irq_o(irq)
  );

  host_model u_host_model (
    .sys_clk_i(sys_clk_i),
    .addr_o(addr),
    .wdata_o(wdata),
    .wr_o(wr),
    .rd_o(rd),
    .rdata_i(rdata)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", what, e, g);
      miscompares++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic st(input logic [7:0] on, input logic [6:0] m,
      input logic o, input logic [7:0] md, input logic a);
    u_host_model.write_reg(`OFF_STATUS, {on, m, o, md, 7'h00, a});
    cyc(2);
  endtask

  task automatic rdst(input logic [31:0] e);
    u_host_model.read_reg(`OFF_STATUS, rv);
    chk("status", e, rv);
  endtask

  // bounded: a dead tick counter must not hang the run
  task automatic period(output int p);
    p = 0;
    for (int i = 0; i < 600 && tick !== 1'b1; i++) cyc(1);
    do begin
      cyc(1);
      p++;
    end while (tick !== 1'b1 && p < 600);
    if (p >= 600) begin
      miscompares++;
      close_out();
    end
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    rst_i = 1'b1;
    flt = 7'h00;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    cyc(1);
    chk("fault_n", 32'h0, 32'(fault_n));
    rdst(32'h0004_0002);
    rdst(32'h0004_0000);
    chk("fault_n", 32'h1, 32'(fault_n));
    st(8'hff, 7'h02, 1'b0, 8'h00, 1'b1);
    chk("ch_en", 32'h0000_00ff, 32'(en));
    chk("active", 32'h1, 32'(act));
    // mode change while channels on must be ignored
    st(8'hff, 7'h02, 1'b0, 8'ha0, 1'b1);
    rdst(32'hff04_0001);
    st(8'hff, 7'h02, 1'b0, 8'h00, 1'b0);
    chk("ch_en", 32'h0, 32'(en));
    st(8'h00, 7'h02, 1'b0, 8'ha0, 1'b1);
    for (int c = 0; c < 4; c++) begin
      st({c[1:0], c[1:0], 4'h0}, 7'h02, 1'b0, 8'ha0, 1'b1);
      chk("ch_hs", 32'({hs_tab[c], 4'h0}), 32'(hs));
      chk("ch_ls", 32'({ls_tab[c], 4'h0}), 32'(ls));
    end
    st(8'h00, 7'h02, 1'b0, 8'ha0, 1'b1);
    st(8'h00, 7'h02, 1'b0, 8'h50, 1'b1);
    chk("partner", 32'h0000_00a0, 32'(par));
    st(8'h00, 7'h02, 1'b0, 8'hc0, 1'b1);
    st(8'hc0, 7'h02, 1'b0, 8'hc0, 1'b1);
    chk("reserved", 32'h0, 32'(en));
    for (int s = 0; s < 2; s++) begin
      st(8'h00, 7'h02, s[0], 8'h00, 1'b1);
      chk("osc_sel", 32'(s), 32'(osc));
      period(n);
      chk("period", s ? `OSC_LO_CYC : `OSC_HI_CYC, 32'(n));
    end
    u_host_model.write_reg(`OFF_IRQ_EN, 32'h0);
    for (int i = 0; i < 7; i++) begin
      st(8'h00, 7'h7f, 1'b0, 8'h00, 1'b1);
      @(posedge sys_clk_i);
      flt <= 7'(1 << i);
      cyc(3);
      chk("fault masked", 32'h1, 32'(fault_n));
      st(8'h00, ~(7'(1) << i), 1'b0, 8'h00, 1'b1);
      chk("fault open", 32'h0, 32'(fault_n));
      rdst({8'h00, ~(7'(1) << i), 9'h0, 7'(1) << i, 1'b1});
      @(posedge sys_clk_i);
      flt <= 7'h00;
      cyc(2);
      u_host_model.read_reg(`OFF_STATUS, rv);
      cyc(2);
      chk("fault idle", 32'h1, 32'(fault_n));
    end
    chk("irq masked", 32'h0, 32'(irq));
    u_host_model.read_reg(`OFF_IRQ_STAT, rv);
    chk("irq status", 32'h7f, rv);
    u_host_model.write_reg(`OFF_IRQ_EN, 32'h7f);
    cyc(2);
    chk("irq", 32'h1, 32'(irq));
    u_host_model.write_reg(`OFF_IRQ_CLR, 32'h7f);
    cyc(2);
    chk("irq cleared", 32'h0, 32'(irq));
    u_host_model.read_reg(8'h10, rv);
    chk("unmapped", 32'h0, rv);
    close_out();
  end
endmodule
